// ---- rirs_core.sv ----
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Pin field: high, low, open-drain, reserved
// - Error policy: hold, zero, pass, reserved
// - Passthrough select routes input to output
// - Input select routes input to decoder
// - Flags stay set until read or disabled
// - Flag read returns then clears flags
// - Disabled flag always reads zero
// - Bit 7 unlock; bits 6,2 reserved
// - Bit 5 new subcode block
// - Bit 4 status buffer, bit 3 user
// - Bit 1 converter over-range
// - Bit 0 any enabled receiver error
// - Enable gates pin and flag, reset 0
// - Enable bit matches flag bit position
// - Two-bit trigger mode across two registers
// - Trigger: rise, fall, level, reserved
// - Pin level set by pin field and active flags
// - Lock algorithm field, default 01
// - Buffer view: status or user data
// - Buffer width: one or two bytes
// - Side select picks channel A or B
// - Status byte reports aux width
// - Only enabled errors alter samples
module rirs_core import rirs_pkg::*; (
    // Clock, enable and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver input pins and routing
    input wire logic [7:0] digital_audio_in,
    output logic passthru_out,
    output logic decoder_in,
    // Interrupt sources from receiver and converter
    input wire logic pll_unlock,
    input wire logic qsub_new,
    input wire logic cs_buf_update,
    input wire logic user_buf_update,
    input wire logic adc_overrange,
    input wire logic [6:0] rx_err,
    // Received samples
    input wire logic [23:0] rx_sample,
    input wire logic rx_sample_valid,
    output logic [23:0] sample_out,
    output logic sample_out_valid,
    // Channel status from decoder, A and B
    input wire logic [7:0] cs_info_a,
    input wire logic [7:0] cs_info_b,
    // Buffer and lock controls
    output logic [1:0] lock_algo_sel,
    output logic buf_view_sel,
    output logic cbuf_width_mode,
    output logic side_sel,
    // Interrupt pin, two signals
    output logic irq_pin_out,
    output logic irq_pin_oe_n
);
    // ==========================================
    // Control registers
    // ==========================================
    logic [7:0] rx_mode; // Pin and policy fields
    logic [7:0] rx_input_routing; // Mux selects
    logic [7:0] irq_flags; // Sticky flags
    logic [7:0] irq_enables; // Per-source enables
    logic [7:0] irq_trigger_upper; // Mode upper bits
    logic [7:0] irq_trigger_lower; // Mode lower bits
    logic [7:0] status_buffer_control; // Lock and view
    logic [7:0] received_status_byte; // Chosen side
    logic [7:0] rx_err_en; // Receiver error enables
    logic [7:0] pins_sync; // Synchronised pins
    logic [23:0] last_good; // Last error-free sample

    // ==========================================
    // APB decode
    // ==========================================
    wire [7:0] reg_idx = {2'b00, paddr[7:2]};
    wire acc = psel & penable;
    wire done = acc & pready;
    wire wr_lane = pwrite & pstrb[0];
    wire hit_mode = (reg_idx == IDX_RX_MODE);
    wire hit_route = (reg_idx == IDX_ROUTING);
    wire hit_flags = (reg_idx == IDX_FLAGS);
    wire hit_en = (reg_idx == IDX_ENABLES);
    wire hit_tup = (reg_idx == IDX_TRIG_UP);
    wire hit_tlo = (reg_idx == IDX_TRIG_LO);
    wire hit_buf = (reg_idx == IDX_BUF_CTRL);
    wire hit_stat = (reg_idx == IDX_STATUS);
    wire hit_erren = (reg_idx == IDX_ERR_EN);
    wire mapped = hit_mode | hit_route | hit_flags | hit_en | hit_tup
        | hit_tlo | hit_buf | hit_stat | hit_erren;
    wire do_wr = done & wr_lane & mapped;
    wire [7:0] wbyte = pwdata[7:0];
    // Flags seen by software: disabled bits read zero
    wire [7:0] flags_vis = irq_flags & irq_enables & FLAG_IMPL;

    // Read data selection
    wire [7:0] next_rbyte =
        hit_mode ? rx_mode :
        hit_route ? rx_input_routing :
        hit_flags ? flags_vis :
        hit_en ? irq_enables :
        hit_tup ? irq_trigger_upper :
        hit_tlo ? irq_trigger_lower :
        hit_buf ? status_buffer_control :
        hit_stat ? received_status_byte :
        hit_erren ? rx_err_en : 8'h00;

    // One wait state: answer lands on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            // Snapshot taken here is what gets cleared later
            if (acc & ~pready) begin
                prdata <= {24'h00_0000, next_rbyte};
            end
        end
    end

    // ==========================================
    // Writable registers
    // ==========================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_mode <= RST_RX_MODE;
            rx_input_routing <= RST_ROUTING;
            irq_enables <= RST_ENABLES;
            irq_trigger_upper <= RST_TRIG;
            irq_trigger_lower <= RST_TRIG;
            status_buffer_control <= RST_BUF_CTRL;
            rx_err_en <= RST_ERR_EN;
        end else if (clk_en && do_wr) begin
            // Writes land at the completing edge only
            if (hit_mode) rx_mode <= wbyte & RX_MODE_MASK;
            if (hit_route) rx_input_routing <= wbyte & ROUTING_MASK;
            if (hit_en) irq_enables <= wbyte & FLAG_IMPL;
            if (hit_tup) irq_trigger_upper <= wbyte & FLAG_IMPL;
            if (hit_tlo) irq_trigger_lower <= wbyte & FLAG_IMPL;
            if (hit_buf) status_buffer_control <= wbyte & BUF_CTRL_MASK;
            if (hit_erren) rx_err_en <= wbyte & ERR_EN_MASK;
        end
    end

    // Field extraction
    wire [1:0] hold_code = rx_mode[POS_HOLD +: 2];
    wire [1:0] pin_code = rx_mode[POS_PIN +: 2];
    wire [2:0] decoder_input_sel = rx_input_routing[POS_DECODER_INPUT_SEL +: 3];
    wire [2:0] passthru_sel = rx_input_routing[POS_PASSTHRU_SEL +: 3];

    // ==========================================
    // Control outputs and status byte
    // ==========================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_algo_sel <= RST_BUF_CTRL[POS_LOCK +: 2];
            buf_view_sel <= 1'b0;
            cbuf_width_mode <= 1'b0;
            side_sel <= 1'b0;
            received_status_byte <= 8'h00;
        end else if (clk_en) begin
            lock_algo_sel <= status_buffer_control[POS_LOCK +: 2];
            buf_view_sel <= status_buffer_control[POS_VIEW];
            cbuf_width_mode <= status_buffer_control[POS_WIDTH];
            side_sel <= status_buffer_control[POS_SIDE];
            // Aux width in 7:4, reserved codes shown as received
            received_status_byte <= status_buffer_control[POS_SIDE]
                ? cs_info_b : cs_info_a;
        end
    end

    // ==========================================
    // Input selection
    // ==========================================
    rirs_sync8 u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(digital_audio_in),
        .sync_out(pins_sync)
    );

    // Both selectors act independently on the same pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            passthru_out <= 1'b0;
            decoder_in <= 1'b0;
        end else if (clk_en) begin
            passthru_out <= pins_sync[passthru_sel];
            decoder_in <= pins_sync[decoder_input_sel];
        end
    end

    // ==========================================
    // Interrupt sources and sticky flags
    // ==========================================
    wire rx_fault_cond = |(rx_err & rx_err_en[6:0]);
    wire [7:0] cond_vec = {pll_unlock, 1'b0, qsub_new, cs_buf_update,
        user_buf_update, 1'b0, adc_overrange, rx_fault_cond};
    wire [7:0] trig_hit;

    // One detector per flag position
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_src
            rirs_trig_det u_det (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .cond(cond_vec[gi]),
                .mode({irq_trigger_upper[gi], irq_trigger_lower[gi]}),
                .hit(trig_hit[gi])
            );
        end
    endgenerate

    // Disabled sources never reach flag or pin
    wire [7:0] ev = trig_hit & irq_enables & FLAG_IMPL;
    wire flag_read = done & ~pwrite & hit_flags;
    // Clear only what software saw; new events win
    wire [7:0] clr_mask = flag_read ? prdata[7:0] : 8'h00;
    wire [7:0] next_flags = (irq_flags & ~clr_mask) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags <= 8'h00;
        end else if (clk_en) begin
            irq_flags <= next_flags & irq_enables;
        end
    end

    // ==========================================
    // Interrupt pin
    // ==========================================
    wire irq_active = |flags_vis;
    // Electrical level depends on the pin field and the visible flags
    wire next_pin_out = (pin_code == RIRS_PIN_HIGH) ? irq_active :
        (pin_code == RIRS_PIN_LOW) ? ~irq_active : 1'b0;
    wire next_pin_oe_n = (pin_code == RIRS_PIN_ODRAIN) ? ~irq_active :
        (pin_code == RIRS_PIN_RSVD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pin_out <= 1'b0;
            irq_pin_oe_n <= 1'b0;
        end else if (clk_en) begin
            irq_pin_out <= next_pin_out;
            irq_pin_oe_n <= next_pin_oe_n;
        end
    end

    // ==========================================
    // Error sample policy
    // ==========================================
    wire sample_err = |(rx_err & rx_err_en[6:0] & ERR_SAMPLE_MASK);
    // Reserved policy code passes samples, the least harmful choice
    wire [23:0] next_sample = !sample_err ? rx_sample :
        (hold_code == RIRS_HOLD_LAST) ? last_good :
        (hold_code == RIRS_HOLD_ZERO) ? 24'h00_0000 : rx_sample;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_out <= 24'h00_0000;
            sample_out_valid <= 1'b0;
            last_good <= 24'h00_0000;
        end else if (clk_en) begin
            sample_out_valid <= rx_sample_valid;
            if (rx_sample_valid) begin
                sample_out <= next_sample;
                if (!sample_err) last_good <= rx_sample;
            end
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_flag_after_read: assert property (
        clk_en && flag_read && ev == 8'h00 |=> (irq_flags & $past(prdata[7:0])) == 8'h00)
        else $error("read flags not cleared");
    chk_event_kept: assert property (
        clk_en && ev[FLG_QSUB] |=> irq_flags[FLG_QSUB])
        else $error("event lost");
    chk_flag_sticky: assert property (
        clk_en && irq_flags[FLG_UNLOCK] && !flag_read && irq_enables[FLG_UNLOCK]
        |=> irq_flags[FLG_UNLOCK])
        else $error("flag dropped without read");
    // Watch what software actually receives, not the internal mask
    chk_disabled_zero: assert property (
        flag_read |-> (prdata[7:0] & ~(irq_enables & FLAG_IMPL)) == 8'h00)
        else $error("disabled flag visible");
    chk_pin_high_mode: assert property (
        clk_en && pin_code == RIRS_PIN_HIGH && irq_active
        |=> irq_pin_out && !irq_pin_oe_n)
        else $error("active-high pin wrong");
    chk_pin_odrain: assert property (
        clk_en && pin_code == RIRS_PIN_ODRAIN |=> !irq_pin_out)
        else $error("open-drain pin drove high");
    chk_rise_mode: assert property (
        clk_en && irq_enables[FLG_OVERRANGE] && irq_trigger_upper[FLG_OVERRANGE] == 1'b0
        && irq_trigger_lower[FLG_OVERRANGE] == 1'b0 && adc_overrange
        && !$past(adc_overrange) |=> irq_flags[FLG_OVERRANGE])
        else $error("rising trigger missed");
    chk_mux_route: assert property (
        clk_en |=> passthru_out == $past(pins_sync[passthru_sel]))
        else $error("passthrough route wrong");
    chk_rx_route: assert property (
        clk_en |=> decoder_in == $past(pins_sync[decoder_input_sel]))
        else $error("decoder route wrong");
    // A low enable must hold flags and the passthrough output exactly
    chk_enable_freeze: assert property (
        !clk_en |=> $stable(irq_flags) && $stable(passthru_out))
        else $error("state moved while frozen");
    chk_zero_policy: assert property (
        clk_en && rx_sample_valid && sample_err && hold_code == RIRS_HOLD_ZERO
        |=> sample_out == 24'h00_0000)
        else $error("error sample not zeroed");
    chk_apb_wait: assert property (
        psel && penable && !pready && clk_en |=> pready)
        else $error("apb answer late");

    cov_flag_read: cover property (flag_read && prdata[7:0] != 8'h00);
    cov_read_and_event: cover property (flag_read && ev != 8'h00);
    cov_fall_trigger: cover property (ev[FLG_UNLOCK] && !pll_unlock);
    cov_hold_last: cover property (rx_sample_valid && sample_err && hold_code == RIRS_HOLD_LAST);
    cov_freeze: cover property (!clk_en ##1 clk_en);
endmodule

// ---- rirs_host.sv ----
`timescale 1ns/100ps
// ==========================================
// APB host model for the register port
// ==========================================
module rirs_host (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Set when the slave never answered
    logic hang = 1'b0;
    // Idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // One transfer; the request stands until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        rd = 8'h00;
        err = 1'b1;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        // Values read right at the edge are the ones that edge samples
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang = 1'b1;
        else begin
            rd = prdata[7:0];
            err = pslverr;
        end
        // Completing edge seen: release now, not one cycle later
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- rirs_pkg.sv ----
// ==========================================
// Register map and field layout
// ==========================================
package rirs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RX_MODE = 8'h1E;
    localparam logic [7:0] IDX_ROUTING = 8'h1F;
    localparam logic [7:0] IDX_FLAGS = 8'h20;
    localparam logic [7:0] IDX_ENABLES = 8'h21;
    localparam logic [7:0] IDX_TRIG_UP = 8'h22;
    localparam logic [7:0] IDX_TRIG_LO = 8'h23;
    localparam logic [7:0] IDX_BUF_CTRL = 8'h24;
    localparam logic [7:0] IDX_STATUS = 8'h25;
    localparam logic [7:0] IDX_ERR_EN = 8'h27;
    // Field positions
    localparam int POS_HOLD = 0;
    localparam int POS_PIN = 2;
    localparam int POS_DECODER_INPUT_SEL = 0;
    localparam int POS_PASSTHRU_SEL = 4;
    localparam int POS_SIDE = 0;
    localparam int POS_WIDTH = 1;
    localparam int POS_VIEW = 2;
    localparam int POS_LOCK = 6;
    localparam int FLG_RX_FAULT = 0;
    localparam int FLG_OVERRANGE = 1;
    localparam int FLG_USER_BUF = 3;
    localparam int FLG_CS_BUF = 4;
    localparam int FLG_QSUB = 5;
    localparam int FLG_UNLOCK = 7;
    // Implemented flag bits; 6 and 2 are reserved
    localparam logic [7:0] FLAG_IMPL = 8'hBB;
    // Writable bits of each control register
    localparam logic [7:0] RX_MODE_MASK = 8'h0F;
    localparam logic [7:0] ROUTING_MASK = 8'h77;
    localparam logic [7:0] BUF_CTRL_MASK = 8'hC7;
    localparam logic [7:0] ERR_EN_MASK = 8'h7F;
    // Sample-altering error bits; checksum errors excluded
    localparam logic [6:0] ERR_SAMPLE_MASK = 7'h1F;
    // Values after reset
    localparam logic [7:0] RST_RX_MODE = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_BUF_CTRL = 8'h40;
    localparam logic [7:0] RST_ERR_EN = 8'h00;
    // Interrupt pin signalling codes
    typedef enum logic [1:0] {
        RIRS_PIN_HIGH = 2'b00,
        RIRS_PIN_LOW = 2'b01,
        RIRS_PIN_ODRAIN = 2'b10,
        RIRS_PIN_RSVD = 2'b11
    } rirs_pin_e;
    // Error sample policy codes
    typedef enum logic [1:0] {
        RIRS_HOLD_LAST = 2'b00,
        RIRS_HOLD_ZERO = 2'b01,
        RIRS_HOLD_PASS = 2'b10,
        RIRS_HOLD_RSVD = 2'b11
    } rirs_hold_e;
    // Trigger mode codes
    typedef enum logic [1:0] {
        RIRS_TRIG_RISE = 2'b00,
        RIRS_TRIG_FALL = 2'b01,
        RIRS_TRIG_LEVEL = 2'b10,
        RIRS_TRIG_RSVD = 2'b11
    } rirs_trig_e;
endpackage

// ---- rirs_sync8.sv ----
`timescale 1ns/100ps
// ==========================================
// Two-stage synchroniser for the input pins
// ==========================================
module rirs_sync8 import rirs_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Pins and synchronised copy
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] meta; // First stage, read only by second

    // Both stages freeze with the clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 8'h00;
            sync_out <= 8'h00;
        end else if (clk_en) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- rirs_trig_det.sv ----
`timescale 1ns/100ps
// ==========================================
// Per-source trigger detector
// ==========================================
module rirs_trig_det import rirs_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Condition and mode
    input wire logic cond,
    input wire logic [1:0] mode,
    output logic hit
);
    logic prev; // Condition one cycle ago

    // Previous value for arrival and removal detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
        end else if (clk_en) begin
            prev <= cond;
        end
    end

    // Mode decode; reserved code never fires
    always_comb begin
        unique case (mode)
            RIRS_TRIG_RISE: hit = cond & ~prev;
            RIRS_TRIG_FALL: hit = ~cond & prev;
            RIRS_TRIG_LEVEL: hit = cond;
            RIRS_TRIG_RSVD: hit = 1'b0;
        endcase
    end
endmodule

// ---- rx_irq_route_status_bench.sv ----
`timescale 1ns/100ps
// ==========================================
// Register, routing and interrupt bench
// ==========================================
module rx_irq_route_status_bench import rirs_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, digital_audio_in, cs_info_a, cs_info_b, cond, rd;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [6:0] err;
    logic [23:0] rx_sample, sample_out;
    logic [1:0] lock_algo_sel;
    logic passthru_out, decoder_in, rx_sample_valid, sample_out_valid, e, buf_view_sel;
    logic cbuf_width_mode, side_sel, irq_pin_out, irq_pin_oe_n;
    logic [2:0] k3;
    int fail_count = 0, check_count = 0;
    // Flag positions of the sources, and pin {out, oe_n} per pin code while active
    int pos [6] = '{7, 5, 4, 3, 1, 0};
    logic [1:0] pin_exp [4] = '{2'b10, 2'b00, 2'b00, 2'b01};
    always #5 pclk = ~pclk;
    rirs_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr);
    rirs_core dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .digital_audio_in, .passthru_out, .decoder_in,
        .pll_unlock(cond[7]), .qsub_new(cond[5]), .cs_buf_update(cond[4]),
        .user_buf_update(cond[3]), .adc_overrange(cond[1]), .rx_err(err | {6'h00, cond[0]}),
        .rx_sample, .rx_sample_valid, .sample_out, .sample_out_valid, .cs_info_a, .cs_info_b,
        .lock_algo_sel, .buf_view_sel, .cbuf_width_mode, .side_sel, .irq_pin_out,
        .irq_pin_oe_n);
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // A hung transfer ends the run at once
    task automatic xf(input logic w, input logic [7:0] idx, input logic [7:0] d);
        host_u.xfer(w, idx, d, rd, e);
        if (host_u.hang) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xf(1'b1, idx, d);
    endtask
    task automatic rdr(input logic [7:0] idx, input logic [7:0] ex, input string nm);
        xf(1'b0, idx, 8'h00);
        chk(nm, ex, rd);
    endtask
    // Let n edges land, then look at settled outputs
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic pulse(input int p);
        @(posedge pclk) cond <= 8'h01 << p;
        @(posedge pclk) cond <= 8'h00;
        w(2);
    endtask
    task automatic hold(input logic v);
        @(posedge pclk) cond <= {6'h00, v, 1'b0};
        w(3);
    endtask
    task automatic send(input logic [23:0] s, input logic [6:0] f, input logic [23:0] ex);
        @(posedge pclk);
        rx_sample <= s;
        err <= f;
        rx_sample_valid <= 1'b1;
        @(posedge pclk);
        rx_sample_valid <= 1'b0;
        err <= 7'h00;
        @(negedge pclk);
        chk("sample_valid", 1, sample_out_valid);
        chk("sample", ex, sample_out);
    endtask
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        {digital_audio_in, cond, err, rx_sample, rx_sample_valid} = '0;
        cs_info_a = 8'h8A;
        cs_info_b = 8'h35;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk("lock_reset", 2'b01, lock_algo_sel);
        rdr(IDX_ENABLES, RST_ENABLES, "enables");
        rdr(IDX_TRIG_UP, RST_TRIG, "trig_up");
        rdr(IDX_TRIG_LO, RST_TRIG, "trig_lo");
        rdr(IDX_BUF_CTRL, RST_BUF_CTRL, "buf_ctrl");
        rdr(IDX_ROUTING, RST_ROUTING, "routing");
        rdr(IDX_FLAGS, 8'h00, "flags_reset");
        rdr(8'h10, 8'h00, "unmapped");
        chk("slverr", 1, e);
        rdr(IDX_STATUS, 8'h8A, "status_a");
        // Lock code 10, user view, two-byte mode, side B
        wr(IDX_BUF_CTRL, 8'h87);
        w(1);
        rdr(IDX_BUF_CTRL, 8'h87, "buf_ctrl");
        chk("ctl_out", 5'b10111, {lock_algo_sel, buf_view_sel, cbuf_width_mode, side_sel});
        wr(IDX_STATUS, 8'h00);
        rdr(IDX_STATUS, 8'h35, "status_b");
        // Each input to passthrough, a different one to the decoder
        for (int k = 0; k < 8; k++) begin
            k3 = k;
            wr(IDX_ROUTING, {1'b0, k3, 1'b0, k3 + 3'd1});
            @(posedge pclk) digital_audio_in <= 8'h01 << k;
            w(5);
            chk("route_hi", 2'b10, {passthru_out, decoder_in});
            @(posedge pclk) digital_audio_in <= ~(8'h01 << k);
            w(5);
            chk("route_lo", 2'b01, {passthru_out, decoder_in});
        end
        // Clock enable low freezes the pin path
        @(posedge pclk) clk_en <= 1'b0;
        digital_audio_in <= 8'hFF;
        w(5);
        chk("frozen", 1'b0, passthru_out);
        @(posedge pclk) clk_en <= 1'b1;
        w(5);
        chk("thawed", 1'b1, passthru_out);
        // Every source, rising mode, pin active high
        wr(IDX_ERR_EN, 8'h7F);
        wr(IDX_ENABLES, FLAG_IMPL);
        for (int i = 0; i < 6; i++) begin
            pulse(pos[i]);
            chk("pin_set", 2'b10, {irq_pin_out, irq_pin_oe_n});
            rdr(IDX_FLAGS, 8'h01 << pos[i], "flag");
            rdr(IDX_FLAGS, 8'h00, "flag_clr");
            w(1);
            chk("pin_clr", 2'b00, {irq_pin_out, irq_pin_oe_n});
        end
        wr(IDX_ENABLES, FLAG_IMPL ^ 8'h02);
        pulse(1);
        rdr(IDX_FLAGS, 8'h00, "masked");
        chk("pin_masked", 2'b00, {irq_pin_out, irq_pin_oe_n});
        // Falling, reserved and level trigger modes
        wr(IDX_ENABLES, FLAG_IMPL);
        wr(IDX_TRIG_LO, 8'h02);
        hold(1'b1);
        rdr(IDX_FLAGS, 8'h00, "fall_arrive");
        hold(1'b0);
        rdr(IDX_FLAGS, 8'h02, "fall_leave");
        wr(IDX_TRIG_UP, 8'h02);
        pulse(1);
        rdr(IDX_FLAGS, 8'h00, "trig_rsvd");
        wr(IDX_TRIG_LO, 8'h00);
        hold(1'b1);
        rdr(IDX_FLAGS, 8'h02, "level");
        rdr(IDX_FLAGS, 8'h02, "level_again");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_RX_MODE, 8'(8'h02 | (c << 2)));
            w(2);
            chk("pin_code", pin_exp[c], {irq_pin_out, irq_pin_oe_n});
        end
        hold(1'b0);
        wr(IDX_RX_MODE, 8'h08);
        rdr(IDX_FLAGS, 8'h02, "level_end");
        w(2);
        chk("drain_idle", 2'b01, {irq_pin_out, irq_pin_oe_n});
        // Sample policy on receiver errors
        wr(IDX_RX_MODE, 8'h00);
        send(24'h123456, 7'h00, 24'h123456);
        send(24'h0ABCDE, 7'h01, 24'h123456);
        wr(IDX_RX_MODE, 8'h01);
        send(24'h0ABCDE, 7'h01, 24'h000000);
        send(24'h0ABCDE, 7'h20, 24'h0ABCDE);
        wr(IDX_RX_MODE, 8'h02);
        send(24'h0FEDCB, 7'h01, 24'h0FEDCB);
        conclude();
    end
    // Run limit
    initial begin
        repeat (50000) @(posedge pclk);
        fail_count++;
        conclude();
    end
endmodule
